/* File: logic/cgu_clock_generation_unit.v */
/*
  clock generation unit control: holds divider factors and mode, sequences
  mode switches, and derives cpu and system clock enables from the
  oscillator clock, plus low-power wake-up detection.
  assumes core_clk is the oscillator clock and the loop vco is modelled by
  a clock enable stream; all inputs synchronous to core_clk.
*/
`timescale 1ns/1ps
`include "cgu_consts.vh"

// Behaviour
// [R1] four clock modes, hardware strap or software
// [R2] direct mode: cpu and system clocks equal oscillator
// [R3] prescaler mode: predivider then postdivider, clocks equal
// [R4] loop mode: osc/p times n, then postdivider; the enable model caps the vco at the oscillator rate
// [R5] base mode: free base frequency through postdivider
// [R6] mode changes run through safe switching sequence
// [R7] wake on enabled interrupt or watchdog 7fff-to-8000
// [R8] wake applies in idle and sleep states
// [R9] factors and mode take effect via switcher
module cgu_clock_generation_unit
#(
  parameter PW = `CGU_PDIV_W,
  parameter NW = `CGU_NMUL_W,
  parameter KW = `CGU_KDIV_W,
  parameter LOCK_CYC = `CGU_LOCK_CYC,
  parameter [NW-1:0] BASE_MUL = 7'h10
)
(
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire hw_cfg_sel,
  input wire [1:0] hw_mode,
  input wire cfg_wr,
  input wire [1:0] cfg_mode,
  input wire [PW-1:0] cfg_pdiv,
  input wire [NW-1:0] cfg_nmul,
  input wire [KW-1:0] cfg_kdiv,
  input wire idle_req,
  input wire sleep_req,
  input wire irq_pending,
  input wire [15:0] watchdog_count_value,
  output reg cpu_clock,
  output reg system_clock,
  output reg [1:0] active_mode,
  output reg switch_busy,
  output reg idle_state,
  output reg sleep_state,
  output reg wake_pulse
);

  localparam ST_RUN = 2'h0;
  localparam ST_GATE = 2'h1;
  localparam ST_LOCK = 2'h2;
  localparam ST_UNGATE = 2'h3;

  reg [1:0] mode_reg;
  reg [PW-1:0] pdiv_reg;
  reg [NW-1:0] nmul_reg;
  reg [KW-1:0] kdiv_reg;
  reg [1:0] st_reg;
  reg [15:0] wait_reg;
  reg [1:0] amode_reg;
  reg [PW-1:0] apdiv_reg;
  reg [NW-1:0] anmul_reg;
  reg [KW-1:0] akdiv_reg;
  reg gate_reg;
  reg [PW-1:0] pcnt_reg;
  reg [NW+PW:0] acc_reg;
  reg [KW-1:0] kcnt_reg;
  reg [15:0] wd_prev_reg;
  reg pstage;
  reg vstage;
  reg [NW+PW:0] acc_sum;
  reg [NW+PW:0] acc_thr;
  reg [NW+PW:0] acc_left;
  reg [NW:0] mul_eff;
  reg kstage_in;
  wire [1:0] req_mode;

  // counter wrap: divide-by-(f+1), f held in a small field
  function wrap;
    input [7:0] cnt;
    input [7:0] fac;
    begin
      wrap = (cnt >= fac);
    end
  endfunction

  // strap wins over software so a board can force a safe mode
  assign req_mode = hw_cfg_sel ? hw_mode : mode_reg; // see [R1]

  // software-held configuration, only staged here
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mode_reg <= `CGU_MODE_DIRECT;
      pdiv_reg <= `CGU_PDIV_RST;
      nmul_reg <= `CGU_NMUL_RST;
      kdiv_reg <= `CGU_KDIV_RST;
    end
    else if (clk_en && cfg_wr)
    begin
      mode_reg <= cfg_mode; // see [R9]
      pdiv_reg <= cfg_pdiv;
      nmul_reg <= cfg_nmul;
      kdiv_reg <= cfg_kdiv;
    end
  end

  // switching sequence: gate clocks, load factors, wait lock, ungate
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= ST_RUN;
      wait_reg <= 16'h0000;
      amode_reg <= `CGU_MODE_DIRECT;
      apdiv_reg <= `CGU_PDIV_RST;
      anmul_reg <= `CGU_NMUL_RST;
      akdiv_reg <= `CGU_KDIV_RST;
      gate_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      case (st_reg)
        ST_RUN:
        begin
          if (req_mode != amode_reg || pdiv_reg != apdiv_reg ||
              nmul_reg != anmul_reg || kdiv_reg != akdiv_reg)
          begin
            gate_reg <= 1'b1; // see [R6]
            wait_reg <= {12'h000, `CGU_GAP_CYC};
            st_reg <= ST_GATE;
          end
        end
        ST_GATE:
        begin
          if (wait_reg == 16'h0000)
          begin
            amode_reg <= req_mode; // see [R9]
            apdiv_reg <= pdiv_reg;
            anmul_reg <= nmul_reg;
            akdiv_reg <= kdiv_reg;
            // only loop-driven modes need the vco to settle
            wait_reg <= (req_mode[1]) ? LOCK_CYC[15:0] : 16'h0000;
            st_reg <= ST_LOCK;
          end
          else
            wait_reg <= wait_reg - 16'h0001;
        end
        ST_LOCK:
        begin
          if (wait_reg == 16'h0000)
          begin
            wait_reg <= {12'h000, `CGU_GAP_CYC};
            st_reg <= ST_UNGATE;
          end
          else
            wait_reg <= wait_reg - 16'h0001;
        end
        ST_UNGATE:
        begin
          if (wait_reg == 16'h0000)
          begin
            gate_reg <= 1'b0; // see [R6]
            st_reg <= ST_RUN;
          end
          else
            wait_reg <= wait_reg - 16'h0001;
        end
        default:
          st_reg <= ST_RUN;
      endcase
    end
  end

  // divider chain as enable stages: p predivider, n feedback, k postdivider
  always @*
  begin
    pstage = (amode_reg == `CGU_MODE_BASE) ? 1'b1 :
             wrap({{(8-PW){1'b0}}, pcnt_reg}, {{(8-PW){1'b0}}, apdiv_reg});
    mul_eff = (amode_reg == `CGU_MODE_BASE) ? {1'b0, BASE_MUL} : // see [R5]
              {1'b0, anmul_reg} + {{NW{1'b0}}, 1'b1};
    // vco rate = osc * (n+1) / (p+1), modelled as fractional accumulator
    acc_sum = acc_reg + {{PW{1'b0}}, mul_eff}; // see [R4]
    acc_thr = {{(NW+1){1'b0}}, apdiv_reg} + {{(NW+PW){1'b0}}, 1'b1};
    vstage = (acc_sum >= acc_thr);
    // residue held at one threshold, or a saturated ratio would wrap and drop a pulse
    acc_left = acc_sum - acc_thr;
    if (!vstage)
      acc_left = acc_sum;
    else if (acc_left > acc_thr)
      acc_left = acc_thr; // see [R4]
    case (amode_reg)
      `CGU_MODE_PRESC: kstage_in = pstage; // see [R3]
      `CGU_MODE_LOOP: kstage_in = vstage;
      `CGU_MODE_BASE: kstage_in = vstage;
      default: kstage_in = 1'b1;
    endcase
  end

  // the enable model caps vco at osc rate; faster loop ratios saturate
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pcnt_reg <= {PW{1'b0}};
      acc_reg <= {(NW+PW+1){1'b0}};
      kcnt_reg <= {KW{1'b0}};
      cpu_clock <= 1'b0;
      system_clock <= 1'b0;
    end
    else if (clk_en)
    begin
      pcnt_reg <= pstage ? {PW{1'b0}} : pcnt_reg + {{(PW-1){1'b0}}, 1'b1};
      acc_reg <= acc_left;
      if (amode_reg == `CGU_MODE_DIRECT)
      begin
        cpu_clock <= !gate_reg && !idle_state && !sleep_state; // see [R2]
        system_clock <= !gate_reg && !sleep_state;
      end
      else if (kstage_in)
      begin
        kcnt_reg <= wrap({{(8-KW){1'b0}}, kcnt_reg}, {{(8-KW){1'b0}}, akdiv_reg}) ?
                    {KW{1'b0}} : kcnt_reg + {{(KW-1){1'b0}}, 1'b1};
        cpu_clock <= !gate_reg && !idle_state && !sleep_state &&
                     wrap({{(8-KW){1'b0}}, kcnt_reg}, {{(8-KW){1'b0}}, akdiv_reg});
        system_clock <= !gate_reg && !sleep_state && // see [R3]
                        wrap({{(8-KW){1'b0}}, kcnt_reg}, {{(8-KW){1'b0}}, akdiv_reg});
      end
      else
      begin
        cpu_clock <= 1'b0;
        system_clock <= 1'b0;
      end
    end
  end

  // low-power states and wake-up; wake beats a same-cycle entry request
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      idle_state <= 1'b0;
      sleep_state <= 1'b0;
      wake_pulse <= 1'b0;
      wd_prev_reg <= 16'h0000;
      active_mode <= `CGU_MODE_DIRECT;
      switch_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      wd_prev_reg <= watchdog_count_value;
      active_mode <= amode_reg;
      switch_busy <= (st_reg != ST_RUN);
      if ((idle_state || sleep_state) && (irq_pending || // see [R7]
          (wd_prev_reg == `CGU_WD_FROM && watchdog_count_value == `CGU_WD_TO)))
      begin
        idle_state <= 1'b0; // see [R8]
        sleep_state <= 1'b0;
        wake_pulse <= 1'b1;
      end
      else
      begin
        wake_pulse <= 1'b0;
        if (sleep_req)
          sleep_state <= 1'b1;
        else if (idle_req && !sleep_state)
          idle_state <= 1'b1;
      end
    end
  end

endmodule

/* File: logic/cgu_consts.vh */
/*
  constants for the clock generation unit: mode codes, divider widths,
  reset values, switching sequence timing and watchdog wake threshold.
  assumes inclusion by the verilog design file and the systemverilog bench.
*/
`ifndef CGU_CONSTS_VH
`define CGU_CONSTS_VH

`define CGU_MODE_DIRECT 2'h0
`define CGU_MODE_PRESC 2'h1
`define CGU_MODE_LOOP 2'h2
`define CGU_MODE_BASE 2'h3

`define CGU_PDIV_W 4
`define CGU_NMUL_W 7
`define CGU_KDIV_W 4

`define CGU_PDIV_RST 4'h0
`define CGU_NMUL_RST 7'h00
`define CGU_KDIV_RST 4'h0

`define CGU_LOCK_NS 1000
`define CGU_CLK_NS 8
`define CGU_LOCK_CYC ((`CGU_LOCK_NS + `CGU_CLK_NS - 1) / `CGU_CLK_NS)
`define CGU_GAP_CYC 4'h4

`define CGU_WD_FROM 16'h7fff
`define CGU_WD_TO 16'h8000

`endif

/* File: test/cgu_checker.sv */
/* port checker for the clock generation unit.
   assumes one clock domain and a bind onto the unit. */
`timescale 1ns/1ps
module cgu_checker (
  input wire core_clk,
  input wire rst_n,
  input wire irq_pending,
  input wire [15:0] watchdog_count_value,
  input wire cpu_clock,
  input wire system_clock,
  input wire [1:0] active_mode,
  input wire switch_busy,
  input wire idle_state,
  input wire sleep_state,
  input wire wake_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // low power means a wake source must answer on the next edge
  wire low_pwr = idle_state | sleep_state;
  // the cpu clock trails idle exit by one registered cycle
  property p_eq; !idle_state && !$past(idle_state) |-> cpu_clock == system_clock; endproperty
  a_eq: assert property (p_eq)
    else $error("cpu and system clock differ");
  // guards skip the cycles where the gate may still be opening
  property p_dir; (active_mode == 2'h0) && !switch_busy && $past(!switch_busy) && !low_pwr
    && $past(!low_pwr) && $past(rst_n) && $past(rst_n, 2) |-> cpu_clock; endproperty
  a_dir: assert property (p_dir)
    else $error("direct mode clock missing");
  property p_gate; $rose(switch_busy) |-> (!cpu_clock && !system_clock) [*4]; endproperty
  a_gate: assert property (p_gate)
    else $error("clock not gated during switch");
  property p_end; $rose(switch_busy) |-> ##[1:300] !switch_busy; endproperty
  a_end: assert property (p_end)
    else $error("switch never ends");
  property p_mode; $changed(active_mode) |-> switch_busy; endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed outside switch");
  property p_irq; low_pwr && irq_pending |=> wake_pulse; endproperty
  a_irq: assert property (p_irq)
    else $error("no wake on interrupt");
  property p_wd; low_pwr && $past(watchdog_count_value) == 16'h7fff
    && watchdog_count_value == 16'h8000 |=> wake_pulse; endproperty
  a_wd: assert property (p_wd)
    else $error("no wake on watchdog");
  property p_slp; sleep_state && $past(sleep_state) |-> !system_clock && !cpu_clock; endproperty
  a_slp: assert property (p_slp)
    else $error("clock runs in sleep");
  c_sw: cover property ($fell(switch_busy) && active_mode == 2'h2);
  c_idle: cover property (idle_state && system_clock);
  c_wake: cover property (wake_pulse && $past(sleep_state));
endmodule
bind cgu_clock_generation_unit cgu_checker chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .irq_pending(irq_pending), .watchdog_count_value(watchdog_count_value),
  .cpu_clock(cpu_clock), .system_clock(system_clock), .active_mode(active_mode),
  .switch_busy(switch_busy), .idle_state(idle_state), .sleep_state(sleep_state),
  .wake_pulse(wake_pulse));

/* File: test/system_clock_generation_bench.sv */
/* bench for the clock generation unit: modes, divider rates, strap, wake.
   assumes the design constants header is on the include path. */
`timescale 1ns/1ps
`include "cgu_consts.vh"
module system_clock_generation_bench;
  reg core_clk, rst_n, clk_en, hw_cfg_sel, cfg_wr, idle_req, sleep_req, irq_pending;
  reg [1:0] hw_mode, cfg_mode;
  reg [3:0] cfg_pdiv, cfg_kdiv;
  reg [6:0] cfg_nmul;
  reg [15:0] watchdog_count_value;
  wire cpu_clock, system_clock, switch_busy, idle_state, sleep_state, wake_pulse;
  wire [1:0] active_mode;
  reg [7:0] c, d;
  integer n_fail, comparisons, cyc;
  // short lock time keeps each switch near twenty cycles
  cgu_clock_generation_unit #(.LOCK_CYC(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .hw_cfg_sel(hw_cfg_sel), .hw_mode(hw_mode), .cfg_wr(cfg_wr),
    .cfg_mode(cfg_mode), .cfg_pdiv(cfg_pdiv), .cfg_nmul(cfg_nmul), .cfg_kdiv(cfg_kdiv),
    .idle_req(idle_req), .sleep_req(sleep_req), .irq_pending(irq_pending),
    .watchdog_count_value(watchdog_count_value), .cpu_clock(cpu_clock),
    .system_clock(system_clock), .active_mode(active_mode), .switch_busy(switch_busy),
    .idle_state(idle_state), .sleep_state(sleep_state), .wake_pulse(wake_pulse));
  initial
  begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  task tick; @(negedge core_clk); endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // bounded wait for the switch sequence to start and finish
  task done;
    integer i;
    for (i = 0; i < 8 && switch_busy !== 1'b1; i++) tick;
    for (i = 0; i < 300 && switch_busy !== 1'b0; i++) tick;
    tick;
    chk("switch end", 8'h00, {7'h00, switch_busy});
  endtask
  task sw(input [1:0] m, input [3:0] p, input [6:0] n, input [3:0] k);
    cfg_mode = m; cfg_pdiv = p; cfg_nmul = n; cfg_kdiv = k;
    cfg_wr = 1; tick; cfg_wr = 0;
    done;
  endtask
  // 60 cycles divide evenly by every period used here
  task cnt;
    integer i;
    c = 8'h00;
    d = 8'h00;
    for (i = 0; i < 60; i++)
    begin
      tick;
      c = c + {7'h00, system_clock};
      d = d + {7'h00, cpu_clock};
    end
  endtask
  task ww;
    integer i;
    c = 8'h00;
    for (i = 0; i < 4 && c == 8'h00; i++) begin tick; c = {7'h00, wake_pulse}; end
  endtask
  task final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task t_modes;
    cnt;
    chk("direct rate", 8'h3c, c);
    chk("direct cpu", 8'h3c, d);
    sw(`CGU_MODE_PRESC, 4'h1, 7'h05, 4'h2);
    cnt;
    chk("presc rate", 8'h0a, c);
    chk("presc cpu", 8'h0a, d);
    chk("mode", {6'h00, `CGU_MODE_PRESC}, {6'h00, active_mode});
    sw(`CGU_MODE_LOOP, 4'h0, 7'h03, 4'h1);
    cnt;
    chk("loop rate", 8'h1e, c);
    chk("loop cpu", 8'h1e, d);
    // a third of the oscillator rate exercises the accumulator, not the cap
    sw(`CGU_MODE_LOOP, 4'h2, 7'h00, 4'h1);
    cnt;
    chk("loop slow rate", 8'h0a, c);
    sw(`CGU_MODE_BASE, 4'h2, 7'h00, 4'h3);
    cnt;
    chk("base rate", 8'h0f, c);
    chk("base cpu", 8'h0f, d);
    $display("modes test done");
  endtask
  task t_strap;
    hw_cfg_sel = 1;
    hw_mode = `CGU_MODE_DIRECT;
    done;
    cnt;
    chk("strap rate", 8'h3c, c);
    chk("strap mode", {6'h00, `CGU_MODE_DIRECT}, {6'h00, active_mode});
    $display("strap test done");
  endtask
  task t_wake;
    idle_req = 1;
    tick;
    idle_req = 0;
    tick;
    tick;
    chk("idle", 8'h01, {7'h00, idle_state});
    cnt;
    chk("idle sys rate", 8'h3c, c);
    chk("idle cpu rate", 8'h00, d);
    chk("idle cpu", 8'h00, {7'h00, cpu_clock});
    irq_pending = 1;
    ww;
    irq_pending = 0;
    chk("irq wake", 8'h01, c);
    tick;
    chk("idle left", 8'h00, {7'h00, idle_state});
    sleep_req = 1;
    tick;
    sleep_req = 0;
    tick;
    tick;
    chk("sleep sys", 8'h00, {7'h00, system_clock});
    watchdog_count_value = 16'h7fff;
    tick;
    // a jump from zero to 7fff is not the wake edge
    chk("wd early", 8'h00, {7'h00, wake_pulse});
    watchdog_count_value = 16'h8000;
    ww;
    chk("wd wake", 8'h01, c);
    tick;
    chk("sleep left", 8'h00, {7'h00, sleep_state});
    $display("wake test done");
  endtask
  // hang guard well above the expected five hundred or so cycles
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000) begin n_fail = n_fail + 1; final_report; end
  end
  initial
  begin
    n_fail = 0; comparisons = 0; cyc = 0; rst_n = 0; clk_en = 1; hw_cfg_sel = 0;
    hw_mode = 2'h0; cfg_wr = 0; cfg_mode = 2'h0; cfg_pdiv = 4'h0; cfg_nmul = 7'h00;
    cfg_kdiv = 4'h0; idle_req = 0; sleep_req = 0; irq_pending = 0;
    watchdog_count_value = 16'h0000;
    repeat (12) tick;
    rst_n = 1; tick; tick;
    t_modes; t_strap; t_wake;
    final_report;
  end
endmodule
